// ==== rtl/cno_node.sv ====
// How it works
// RULE1: pdo1 carries digital, pdo2 analog data, reserved before any other pdo.
// RULE2: later pdos: extra digital, 1-byte special, analog, then 2..8-byte special.
// RULE3: one data type per pdo; a type change opens a fresh pdo.
// RULE4: after initialization the node enters pre-operational on its own.
// RULE5: pre-operational keeps sdo access enabled on default identifiers.
// RULE6: pre-operational neither sends nor acts on pdos.
// RULE7: nmt frame id 0, bytes 0x01 0x00 moves the node to operational.
// RULE8: every object starts from its default; defaults reload on reset.
// RULE9: nmt frames: id 0, command then address; own address or 0 accepted.
// RULE10: 0x80 pre-op, 0x02 stop with fault outputs, 0x81 node reset, 0x82 comm reset.
// RULE11: after init send boot-up: id 0x700 plus node address, one zero byte.
// RULE12: operational exchanges pdos and keeps sdo access.
// RULE13: at most eight bytes per pdo; a full pdo continues in a new one.
`timescale 1ns/1ns
`default_nettype none
module cno_node (
  input  wire logic        SYS_CLK,       // 100 MHz system clock
  input  wire logic        SRST,          // sync reset, high
  input  wire logic [6:0]  NODE_ADDR,     // address switches, asynchronous
  input  wire logic        RX_VALID,      // received frame strobe
  input  wire logic [10:0] RX_ID,         // received identifier
  input  wire logic [3:0]  RX_DLC,        // received length
  input  wire logic [7:0]  RX_DATA0,      // first data byte
  input  wire logic [7:0]  RX_DATA1,      // second data byte
  output logic             TX_REQ,        // boot-up frame request
  output logic [10:0]      TX_ID,         // frame identifier
  output logic [3:0]       TX_DLC,        // frame length
  output logic [7:0]       TX_DATA,       // frame data byte
  input  wire logic        TX_ACK,        // frame sent
  output logic             SDO_EN,        // sdo server enabled
  output logic             PDO_EN,        // pdo exchange enabled
  output logic             OUT_FAULT,     // outputs to fault state
  output logic [7:0]       NMT_STATE,     // status code
  output logic             OBJ_DEFAULTS,  // load all object defaults
  output logic             COMM_DEFAULTS, // load comm object defaults
  input  wire logic [7:0]  TX_DIG_BYTES,  // digital input bytes
  input  wire logic [7:0]  TX_ANA_CH,     // analog input channels
  input  wire logic [63:0] TX_SPEC_CNT,   // input special module counts
  input  wire logic [7:0]  RX_DIG_BYTES,  // digital output bytes
  input  wire logic [7:0]  RX_ANA_CH,     // analog output channels
  input  wire logic [63:0] RX_SPEC_CNT,   // output special module counts
  output logic             TX_MAP_VALID,  // transmit mapping entry
  output logic [7:0]       TX_MAP_PDO,    // transmit pdo number
  output logic [3:0]       TX_MAP_TYPE,   // transmit data type
  output logic [3:0]       TX_MAP_BYTES,  // transmit pdo length
  output logic             RX_MAP_VALID,  // receive mapping entry
  output logic [7:0]       RX_MAP_PDO,    // receive pdo number
  output logic [3:0]       RX_MAP_TYPE,   // receive data type
  output logic [3:0]       RX_MAP_BYTES,  // receive pdo length
  output logic             MAP_READY      // both mappings complete
);
  cno_pkg::cno_nmt_e state_reg;
  cno_pkg::cno_nmt_e state_next;
  logic [6:0]        node_s1_reg;
  logic [6:0]        node_s2_reg;
  logic [6:0]        node_reg;
  logic              full_reg;
  logic              full_next;
  logic              nmt_hit;
  logic              running;

  cno_map_if txm ();
  cno_map_if rxm ();

  // address switches are asynchronous: two flops before use
  // no reset here, so the switches are already settled when init takes them
  always_ff @(posedge SYS_CLK) begin
    node_s1_reg <= NODE_ADDR;
    node_s2_reg <= node_s1_reg;
  end

  // the address is only taken during init, so a switch change needs a reset
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      node_reg <= 7'h00;
    end else if (state_reg == cno_pkg::ST_INIT) begin
      node_reg <= node_s2_reg;
    end
  end

  // nmt frame filter
  assign running = (state_reg == cno_pkg::ST_PREOP) || (state_reg == cno_pkg::ST_OPER) ||
                   (state_reg == cno_pkg::ST_STOP);
  assign nmt_hit = running && RX_VALID && RX_ID == cno_pkg::NMT_ID && RX_DLC == cno_pkg::NMT_DLC &&
                   (RX_DATA1 == cno_pkg::NMT_BROADCAST || RX_DATA1 == {1'b0, node_reg}); // RULE9

  // next state; frames during init and boot-up are ignored
  always_comb begin
    state_next = state_reg;
    full_next  = full_reg;
    case (state_reg)
      cno_pkg::ST_INIT: state_next = cno_pkg::ST_MAPW;
      cno_pkg::ST_MAPW: begin
        if (txm.done && rxm.done) begin
          state_next = cno_pkg::ST_BOOT;
        end
      end
      cno_pkg::ST_BOOT: begin
        if (TX_ACK) begin
          state_next = cno_pkg::ST_PREOP; // RULE4
        end
      end
      cno_pkg::ST_PREOP, cno_pkg::ST_OPER, cno_pkg::ST_STOP: begin
        if (nmt_hit) begin
          case (RX_DATA0)
            cno_pkg::CMD_START: state_next = cno_pkg::ST_OPER;  // RULE7
            cno_pkg::CMD_PREOP: state_next = cno_pkg::ST_PREOP; // RULE10
            cno_pkg::CMD_STOP:  state_next = cno_pkg::ST_STOP;  // RULE10
            cno_pkg::CMD_RESET_NODE: begin
              state_next = cno_pkg::ST_INIT; // RULE10
              full_next  = 1'b1;
            end
            cno_pkg::CMD_RESET_COMM: begin
              state_next = cno_pkg::ST_INIT; // RULE10
              full_next  = 1'b0;
            end
            default: state_next = state_reg;
          endcase
        end
      end
      default: state_next = cno_pkg::ST_INIT;
    endcase
  end

  // state register; power-on counts as a full node reset
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_reg <= cno_pkg::ST_INIT;
      full_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      full_reg  <= full_next;
    end
  end

  // default reload pulses, one cycle: during init on nmt resets, the cycle after init at power-on
  // power-on leaves reset already in init, so the second term gives its pulse
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      OBJ_DEFAULTS  <= 1'b0;
      COMM_DEFAULTS <= 1'b0;
    end else begin
      OBJ_DEFAULTS  <= ((state_next == cno_pkg::ST_INIT) && full_next) ||
                       ((state_reg == cno_pkg::ST_INIT) && full_reg && !OBJ_DEFAULTS); // RULE8
      COMM_DEFAULTS <= (state_next == cno_pkg::ST_INIT) && !full_next; // RULE8
    end
  end

  // state-derived enables, registered so they move with the state
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      SDO_EN    <= 1'b0;
      PDO_EN    <= 1'b0;
      OUT_FAULT <= 1'b0;
      NMT_STATE <= cno_pkg::STAT_INIT;
    end else begin
      SDO_EN    <= (state_next == cno_pkg::ST_PREOP) || (state_next == cno_pkg::ST_OPER); // RULE5 RULE12
      PDO_EN    <= (state_next == cno_pkg::ST_OPER); // RULE6 RULE12
      OUT_FAULT <= (state_next == cno_pkg::ST_STOP); // RULE10
      case (state_next)
        cno_pkg::ST_PREOP: NMT_STATE <= cno_pkg::STAT_PREOP;
        cno_pkg::ST_OPER:  NMT_STATE <= cno_pkg::STAT_OPER;
        cno_pkg::ST_STOP:  NMT_STATE <= cno_pkg::STAT_STOPPED;
        default:           NMT_STATE <= cno_pkg::STAT_INIT;
      endcase
    end
  end

  // boot-up frame contents, fixed once the address is known
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      TX_ID   <= cno_pkg::BOOT_ID_BASE;
      TX_DLC  <= cno_pkg::BOOT_DLC;
      TX_DATA <= cno_pkg::BOOT_DATA;
    end else if (state_reg == cno_pkg::ST_MAPW) begin
      TX_ID   <= cno_pkg::BOOT_ID_BASE + {4'h0, node_reg}; // RULE11
      TX_DLC  <= cno_pkg::BOOT_DLC;
      TX_DATA <= cno_pkg::BOOT_DATA;
    end
  end

  assign TX_REQ = (state_reg == cno_pkg::ST_BOOT); // RULE11

  // mapping is rebuilt from the module counts on every init
  assign txm.start     = (state_reg == cno_pkg::ST_INIT); // RULE1
  assign txm.dig_bytes = TX_DIG_BYTES;
  assign txm.ana_ch    = TX_ANA_CH;
  assign txm.spec_cnt  = TX_SPEC_CNT;
  assign rxm.start     = (state_reg == cno_pkg::ST_INIT);
  assign rxm.dig_bytes = RX_DIG_BYTES;
  assign rxm.ana_ch    = RX_ANA_CH;
  assign rxm.spec_cnt  = RX_SPEC_CNT;

  cno_pdo_map #(.MAX_BYTES(cno_pkg::PDO_BYTES)) u_tx_map (
    .clk  (SYS_CLK),
    .srst (SRST),
    .m    (txm.mapper)
  );

  cno_pdo_map #(.MAX_BYTES(cno_pkg::PDO_BYTES)) u_rx_map (
    .clk  (SYS_CLK),
    .srst (SRST),
    .m    (rxm.mapper)
  );

  assign TX_MAP_VALID = txm.ent_valid;
  assign TX_MAP_PDO   = txm.ent_pdo;
  assign TX_MAP_TYPE  = txm.ent_type;
  assign TX_MAP_BYTES = txm.ent_bytes;
  assign RX_MAP_VALID = rxm.ent_valid;
  assign RX_MAP_PDO   = rxm.ent_pdo;
  assign RX_MAP_TYPE  = rxm.ent_type;
  assign RX_MAP_BYTES = rxm.ent_bytes;
  assign MAP_READY    = txm.done && rxm.done;

  property p_boot_to_preop;
    @(posedge SYS_CLK) disable iff (SRST)
    TX_REQ && TX_ACK |=> NMT_STATE == cno_pkg::STAT_PREOP && SDO_EN && !PDO_EN;
  endproperty
  a_boot_to_preop: assert property (p_boot_to_preop) else $error("no pre-op after boot-up"); // RULE4

  property p_preop_sdo;
    @(posedge SYS_CLK) disable iff (SRST)
    NMT_STATE == cno_pkg::STAT_PREOP |-> SDO_EN && !PDO_EN;
  endproperty
  a_preop_sdo: assert property (p_preop_sdo) else $error("pre-op enables wrong"); // RULE5 RULE6

  property p_start;
    @(posedge SYS_CLK) disable iff (SRST)
    running && RX_VALID && RX_ID == 11'h000 && RX_DLC == 4'h2 && RX_DATA0 == 8'h01 && RX_DATA1 == 8'h00
      |=> NMT_STATE == cno_pkg::STAT_OPER && PDO_EN && SDO_EN;
  endproperty
  a_start: assert property (p_start) else $error("start command ignored"); // RULE7 RULE12

  property p_foreign;
    @(posedge SYS_CLK) disable iff (SRST)
    running && RX_VALID && RX_DATA1 != 8'h00 && RX_DATA1 != {1'b0, node_reg} |=> $stable(NMT_STATE);
  endproperty
  a_foreign: assert property (p_foreign) else $error("acted on foreign nmt frame"); // RULE9

  property p_stop;
    @(posedge SYS_CLK) disable iff (SRST)
    nmt_hit && RX_DATA0 == 8'h02 |=> OUT_FAULT && !SDO_EN && !PDO_EN;
  endproperty
  a_stop: assert property (p_stop) else $error("stop command not applied"); // RULE10

  property p_reset_node;
    @(posedge SYS_CLK) disable iff (SRST)
    nmt_hit && RX_DATA0 == 8'h81 |=> OBJ_DEFAULTS && !COMM_DEFAULTS ##1 !OBJ_DEFAULTS && NMT_STATE == 8'h00;
  endproperty
  a_reset_node: assert property (p_reset_node) else $error("node reset not carried out"); // RULE8 RULE10

  property p_boot_frame;
    @(posedge SYS_CLK) disable iff (SRST)
    TX_REQ |-> TX_ID == 11'h700 + {4'h0, node_reg} && TX_DLC == 4'h1 && TX_DATA == 8'h00;
  endproperty
  a_boot_frame: assert property (p_boot_frame) else $error("boot-up frame malformed"); // RULE11

  property p_boot_after_map;
    @(posedge SYS_CLK) disable iff (SRST)
    $rose(TX_REQ) |-> $past(MAP_READY) && !PDO_EN;
  endproperty
  a_boot_after_map: assert property (p_boot_after_map) else $error("boot-up before mapping done"); // RULE1
endmodule
`default_nettype wire

// ==== rtl/cno_pkg.sv ====
`default_nettype none
package cno_pkg;
  // nmt frame layout and commands
  localparam logic [10:0] NMT_ID          = 11'h000;
  localparam logic [3:0]  NMT_DLC         = 4'h2;
  localparam logic [7:0]  NMT_BROADCAST   = 8'h00;
  localparam logic [7:0]  CMD_START       = 8'h01;
  localparam logic [7:0]  CMD_STOP        = 8'h02;
  localparam logic [7:0]  CMD_PREOP       = 8'h80;
  localparam logic [7:0]  CMD_RESET_NODE  = 8'h81;
  localparam logic [7:0]  CMD_RESET_COMM  = 8'h82;
  // boot-up frame
  localparam logic [10:0] BOOT_ID_BASE    = 11'h700;
  localparam logic [3:0]  BOOT_DLC        = 4'h1;
  localparam logic [7:0]  BOOT_DATA       = 8'h00;
  // status codes reported on the state output
  localparam logic [7:0]  STAT_INIT       = 8'h00;
  localparam logic [7:0]  STAT_STOPPED    = 8'h04;
  localparam logic [7:0]  STAT_OPER       = 8'h05;
  localparam logic [7:0]  STAT_PREOP      = 8'h7F;
  // pdo packing
  localparam int          PDO_BYTES       = 8;
  localparam logic [7:0]  DIG_FIRST_BYTES = 8'h08;
  localparam logic [7:0]  ANA_FIRST_CH    = 8'h04;
  localparam logic [7:0]  FIRST_FREE_PDO  = 8'h03;
  // mapping phases, in assignment order; the phase is the data type code
  localparam logic [3:0]  PH_DIG_FIRST    = 4'h0;
  localparam logic [3:0]  PH_ANA_FIRST    = 4'h1;
  localparam logic [3:0]  PH_DIG_REST     = 4'h2;
  localparam logic [3:0]  PH_SPEC1        = 4'h3;
  localparam logic [3:0]  PH_ANA_REST     = 4'h4;
  localparam logic [3:0]  PH_SPEC2        = 4'h5;
  localparam logic [3:0]  PH_LAST         = 4'hB;

  typedef enum logic [5:0] {
    ST_INIT  = 6'h01,
    ST_MAPW  = 6'h02,
    ST_BOOT  = 6'h04,
    ST_PREOP = 6'h08,
    ST_OPER  = 6'h10,
    ST_STOP  = 6'h20
  } cno_nmt_e;

  typedef enum logic [2:0] {
    MP_IDLE = 3'h1,
    MP_RUN  = 3'h2,
    MP_DONE = 3'h4
  } cno_map_e;
endpackage
`default_nettype wire

// ==== rtl/cno_map_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface cno_map_if;
  logic        start;     // one-cycle request to rebuild the mapping
  logic [7:0]  dig_bytes; // digital process data, bytes
  logic [7:0]  ana_ch;    // analog channels, two bytes each
  logic [63:0] spec_cnt;  // byte k: count of (k+1)-byte special modules
  logic        done;      // mapping complete, level
  logic        ent_valid; // one entry pulse
  logic [7:0]  ent_pdo;   // pdo number
  logic [3:0]  ent_type;  // data type (phase code)
  logic [3:0]  ent_bytes; // bytes used in that pdo

  modport mapper (input start, dig_bytes, ana_ch, spec_cnt,
                  output done, ent_valid, ent_pdo, ent_type, ent_bytes);
  modport ctrl   (output start, dig_bytes, ana_ch, spec_cnt,
                  input done, ent_valid, ent_pdo, ent_type, ent_bytes);
endinterface
`default_nettype wire

// ==== rtl/cno_pdo_map.sv ====
`timescale 1ns/1ns
`default_nettype none
module cno_pdo_map #(
  parameter int MAX_BYTES = cno_pkg::PDO_BYTES
) (
  input wire logic  clk,  // system clock
  input wire logic  srst, // sync reset, high
  cno_map_if.mapper m     // counts in, entries out
);
  // first two pdos assume the full eight-byte payload
  if (MAX_BYTES != cno_pkg::PDO_BYTES) begin : g_chk
    $error("cno_pdo_map: MAX_BYTES must be 8");
  end

  cno_pkg::cno_map_e state_reg;
  logic [3:0]        phase_reg;
  logic [7:0]        rem_reg;
  logic [3:0]        fill_reg;
  logic [7:0]        pdo_reg;
  logic [3:0]        size;
  logic              phase_end;
  logic              full;
  logic              emit_now;

  // elements left for a phase; first pdos capped at their payload
  function automatic logic [7:0] rem_of(input logic [3:0] ph);
    logic [7:0] r;
    r = 8'h00;
    case (ph)
      cno_pkg::PH_DIG_FIRST: r = (m.dig_bytes > cno_pkg::DIG_FIRST_BYTES) ? cno_pkg::DIG_FIRST_BYTES : m.dig_bytes;
      cno_pkg::PH_ANA_FIRST: r = (m.ana_ch > cno_pkg::ANA_FIRST_CH) ? cno_pkg::ANA_FIRST_CH : m.ana_ch;
      cno_pkg::PH_DIG_REST:  r = (m.dig_bytes > cno_pkg::DIG_FIRST_BYTES) ? m.dig_bytes - cno_pkg::DIG_FIRST_BYTES : 8'h00;
      cno_pkg::PH_SPEC1:     r = m.spec_cnt[7:0];
      cno_pkg::PH_ANA_REST:  r = (m.ana_ch > cno_pkg::ANA_FIRST_CH) ? m.ana_ch - cno_pkg::ANA_FIRST_CH : 8'h00;
      default:               r = (ph > cno_pkg::PH_LAST) ? 8'h00 : m.spec_cnt[8*(int'(ph)-4) +: 8];
    endcase
    return r;
  endfunction

  // element size in bytes for the current phase
  always_comb begin
    case (phase_reg)
      cno_pkg::PH_ANA_FIRST, cno_pkg::PH_ANA_REST: size = 4'h2;
      cno_pkg::PH_DIG_FIRST, cno_pkg::PH_DIG_REST, cno_pkg::PH_SPEC1: size = 4'h1;
      default: size = phase_reg - 4'h3;
    endcase
  end

  assign phase_end = (rem_reg == 8'h00);
  assign full      = ({1'b0, fill_reg} + {1'b0, size}) > 5'(MAX_BYTES); // RULE13
  // pdo1/pdo2 are reserved even when empty; others only when used
  assign emit_now  = (state_reg == cno_pkg::MP_RUN) &&
                     ((phase_end && (fill_reg != 4'h0 || phase_reg <= cno_pkg::PH_ANA_FIRST)) || // RULE1
                      (!phase_end && full));

  // packing walk: at most one element per cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= cno_pkg::MP_IDLE;
      phase_reg <= 4'h0;
      rem_reg   <= 8'h00;
      fill_reg  <= 4'h0;
      pdo_reg   <= 8'h01;
    end else begin
      case (state_reg)
        cno_pkg::MP_IDLE, cno_pkg::MP_DONE: begin
          if (m.start) begin
            state_reg <= cno_pkg::MP_RUN;
            phase_reg <= cno_pkg::PH_DIG_FIRST;
            rem_reg   <= rem_of(cno_pkg::PH_DIG_FIRST);
            fill_reg  <= 4'h0;
            pdo_reg   <= 8'h01;
          end
        end
        cno_pkg::MP_RUN: begin
          if (phase_end) begin
            // type change always closes the open pdo
            fill_reg <= 4'h0; // RULE3
            if (emit_now) begin
              pdo_reg <= pdo_reg + 8'h01;
            end
            if (phase_reg == cno_pkg::PH_LAST) begin
              state_reg <= cno_pkg::MP_DONE;
            end else begin
              phase_reg <= phase_reg + 4'h1; // RULE2
              rem_reg   <= rem_of(phase_reg + 4'h1);
            end
          end else if (full) begin
            fill_reg <= 4'h0; // RULE13
            pdo_reg  <= pdo_reg + 8'h01;
          end else begin
            fill_reg <= fill_reg + size;
            rem_reg  <= rem_reg - 8'h01;
          end
        end
        default: state_reg <= cno_pkg::MP_IDLE;
      endcase
    end
  end

  // entry outputs are registered copies of the closing pdo
  always_ff @(posedge clk) begin
    if (srst) begin
      m.ent_valid <= 1'b0;
      m.ent_pdo   <= 8'h00;
      m.ent_type  <= 4'h0;
      m.ent_bytes <= 4'h0;
    end else begin
      m.ent_valid <= emit_now;
      if (emit_now) begin
        m.ent_pdo   <= pdo_reg;
        m.ent_type  <= phase_reg;
        m.ent_bytes <= fill_reg;
      end
    end
  end

  assign m.done = (state_reg == cno_pkg::MP_DONE);

  // helper: type of the previous entry
  logic [3:0] last_type_reg;
  logic       seen_reg;
  always_ff @(posedge clk) begin
    if (srst || m.start) begin
      last_type_reg <= 4'h0;
      seen_reg      <= 1'b0;
    end else if (m.ent_valid) begin
      last_type_reg <= m.ent_type;
      seen_reg      <= 1'b1;
    end
  end

  property p_first_pdos;
    @(posedge clk) disable iff (srst)
    m.ent_valid && m.ent_type <= cno_pkg::PH_ANA_FIRST |-> m.ent_pdo == {7'h00, 1'b1} + {4'h0, m.ent_type};
  endproperty
  a_first_pdos: assert property (p_first_pdos) else $error("pdo1/pdo2 not reserved"); // RULE1

  property p_order;
    @(posedge clk) disable iff (srst)
    m.ent_valid && seen_reg |-> m.ent_type >= last_type_reg;
  endproperty
  a_order: assert property (p_order) else $error("mapping order broken"); // RULE2

  property p_no_mix;
    @(posedge clk) disable iff (srst)
    m.ent_valid ##1 m.ent_valid |-> m.ent_pdo == $past(m.ent_pdo) + 8'h01;
  endproperty
  a_no_mix: assert property (p_no_mix) else $error("pdo reused across entries"); // RULE3

  property p_limit;
    @(posedge clk) disable iff (srst)
    m.ent_valid |-> m.ent_bytes <= 4'h8 && (m.ent_bytes != 4'h0 || m.ent_type <= cno_pkg::PH_ANA_FIRST);
  endproperty
  a_limit: assert property (p_limit) else $error("pdo payload out of range"); // RULE13
endmodule
`default_nettype wire

// ==== verif/cno_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// network master: sends nmt frames, acks the boot-up frame
module cno_master_model (
  input  wire logic        clk, // system clock
  input  wire logic        req, // node frame pending
  output logic             vld, // frame strobe
  output logic [10:0]      id,  // identifier
  output logic [3:0]       dlc, // length
  output logic [7:0]       d0,  // command byte
  output logic [7:0]       d1,  // address byte
  output logic             ack  // frame sent
);
  int dly = 0;
  // fields flip outside the strobe so stale values never look valid
  task automatic send(input logic [30:0] f);
    @(posedge clk);
    #1;
    vld = 1'b1;
    {id, dlc, d0, d1} = f;
    @(posedge clk);
    #1;
    vld = 1'b0;
    {id, dlc, d0, d1} = ~f;
  endtask
  // ack after dly cycles; dly lets a scenario be prompt or slow
  initial begin
    vld = 1'b0;
    ack = 1'b0;
    {id, dlc, d0, d1} = 31'h7FFFFFFF;
    forever begin
      @(posedge clk);
      #1;
      if (req === 1'b1) begin
        repeat (dly) begin
          @(posedge clk);
          #1;
        end
        ack = 1'b1;
        @(posedge clk);
        #1;
        ack = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/canopen_node_pdo_nmt_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module canopen_node_pdo_nmt_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [6:0]  addr;
  logic        vld, req, ack, sdo, pdo, flt, objd, comd, tmv, rmv, rdy;
  logic [10:0] id, tx_id;
  logic [3:0]  dlc, tx_dlc, tmt, tmb, rmt, rmb;
  logic [7:0]  d0, d1, tx_data, st, tdig, tana, rdig, rana, tmp, rmp;
  logic [63:0] tspec, rspec;
  logic [15:0] q_tx[$], q_rx[$];
  int          mismatches = 0, checks_done = 0, cycles = 0, objs = 0, comms = 0;
  int          seed = 32'h6201;
  always #5 clk = ~clk;
  cno_node DUT (.SYS_CLK(clk), .SRST(srst), .NODE_ADDR(addr), .RX_VALID(vld), .RX_ID(id),
    .RX_DLC(dlc), .RX_DATA0(d0), .RX_DATA1(d1), .TX_REQ(req), .TX_ID(tx_id), .TX_DLC(tx_dlc),
    .TX_DATA(tx_data), .TX_ACK(ack), .SDO_EN(sdo), .PDO_EN(pdo), .OUT_FAULT(flt), .NMT_STATE(st),
    .OBJ_DEFAULTS(objd), .COMM_DEFAULTS(comd), .TX_DIG_BYTES(tdig), .TX_ANA_CH(tana),
    .TX_SPEC_CNT(tspec), .RX_DIG_BYTES(rdig), .RX_ANA_CH(rana), .RX_SPEC_CNT(rspec),
    .TX_MAP_VALID(tmv), .TX_MAP_PDO(tmp), .TX_MAP_TYPE(tmt), .TX_MAP_BYTES(tmb),
    .RX_MAP_VALID(rmv), .RX_MAP_PDO(rmp), .RX_MAP_TYPE(rmt), .RX_MAP_BYTES(rmb), .MAP_READY(rdy));
  cno_master_model m (.clk(clk), .req(req), .vld(vld), .id(id), .dlc(dlc), .d0(d0), .d1(d1), .ack(ack));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // predicted pdo list; elements are never split across pdos
  task automatic build(input logic [7:0] dg, input logic [7:0] an, input logic [63:0] sp, input bit rx);
    int n, s, k, p;
    logic [15:0] e[$];
    p = 3;
    e.push_back({8'h01, 4'h0, 4'(dg > 8 ? 8 : dg)});
    e.push_back({8'h02, 4'h1, 4'(an > 4 ? 8 : 2 * an)});
    for (int ph = 2; ph < 12; ph++) begin
      s = ph < 4 ? 1 : (ph == 4 ? 2 : ph - 3);
      n = ph == 2 ? (dg > 8 ? dg - 8 : 0) : (ph == 4 ? (an > 4 ? an - 4 : 0) : 0);
      if (ph == 3) n = sp[7:0];
      if (ph > 4) n = sp[8 * (ph - 4) +: 8];
      while (n > 0) begin
        k = n < 8 / s ? n : 8 / s;
        e.push_back({8'(p), 4'(ph), 4'(k * s)});
        p++;
        n -= k;
      end
    end
    if (rx) q_rx = e;
    else q_tx = e;
  endtask
  // new address and module counts, held until the mapping ends
  task automatic shuffle();
    addr = 7'(1 + {$random(seed)} % 63);
    {tdig, tana, rdig, rana} = $random(seed) & 32'h1F0F1F0F;
    tspec = {$random(seed), $random(seed)} & {8{8'h03}};
    rspec = {$random(seed), $random(seed)} & {8{8'h03}};
    build(tdig, tana, tspec, 1'b0);
    build(rdig, rana, rspec, 1'b1);
  endtask
  // one frame, then the state outputs once the change has landed
  task automatic frame(input logic [30:0] f, input logic [7:0] s, input logic [2:0] en);
    m.send(f);
    repeat (2) @(posedge clk);
    #1;
    check({st, sdo, pdo, flt}, {s, en});
  endtask
  // boot-up frame, then pre-operational with every entry seen
  task automatic boot();
    int n;
    n = 0;
    while (req !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({tx_id, tx_dlc, tx_data}, {11'h700 + 11'(addr), 4'h1, 8'h00});
    while (st !== 8'h7F && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({st, sdo, pdo, flt, rdy}, {8'h7F, 4'b1001});
    check(q_tx.size() + q_rx.size(), 0);
  endtask
  // entries compared in arrival order; a hang is cut short here too
  always @(posedge clk) begin
    cycles++;
    if (tmv === 1'b1) check({tmp, tmt, tmb}, q_tx.size() ? q_tx.pop_front() : 16'hFFFF);
    if (rmv === 1'b1) check({rmp, rmt, rmb}, q_rx.size() ? q_rx.pop_front() : 16'hFFFF);
    if (objd === 1'b1) objs++;
    if (comd === 1'b1) comms++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    shuffle();
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    m.send({11'h000, 4'h2, 8'h01, 8'h00});
    boot();
    check(objs, 1);
    frame({11'h001, 4'h2, 8'h01, 8'h00}, 8'h7F, 3'b100);
    frame({11'h000, 4'h3, 8'h01, 8'h00}, 8'h7F, 3'b100);
    frame({11'h000, 4'h2, 8'h01, 1'b1, addr}, 8'h7F, 3'b100);
    frame({11'h000, 4'h2, 8'h55, 8'h00}, 8'h7F, 3'b100);
    frame({11'h000, 4'h2, 8'h01, 1'b0, addr}, 8'h05, 3'b110);
    frame({11'h000, 4'h2, 8'h80, 8'h00}, 8'h7F, 3'b100);
    frame({11'h000, 4'h2, 8'h02, 8'h00}, 8'h04, 3'b001);
    frame({11'h000, 4'h2, 8'h01, 8'h00}, 8'h05, 3'b110);
    frame({11'h000, 4'h2, 8'h02, 1'b0, addr}, 8'h04, 3'b001);
    frame({11'h000, 4'h2, 8'h80, 8'h00}, 8'h7F, 3'b100);
    // node reset then comm reset, with a slow master ack
    for (int r = 0; r < 2; r++) begin
      m.dly = 3 + r * 4;
      shuffle();
      repeat (3) @(posedge clk);
      #1;
      frame({11'h000, 4'h2, r ? 8'h82 : 8'h81, 8'h00}, 8'h00, 3'b000);
      boot();
      check(objs * 4 + comms, 8 + r);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
